// ===== pkg/dbrb_pkg.sv
/*
 * Constants, command codes and helpers shared by both link ends.
 * Assumes a single 125 MHz system clock in each end.
 */
package dbrb_pkg;

    // ==========================================================
    // link geometry
    localparam int BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 13;
    localparam int COL_W = 10;
    localparam int DQ_W = 16;
    localparam int BEAT_W = 4;
    // auto-precharge on a read, all banks on a precharge
    localparam int AP_BIT = 10;
    localparam int CHOP_BIT = 12;
    localparam int COL_NIBBLE_BIT = 2;
    localparam int DATA_ROW_W = 6;
    localparam int DATA_COL_W = 4;

    // ==========================================================
    // burst length field of mode_register_zero
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_ON_THE_FLY = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [BEAT_W-1:0] BEATS_8 = 4'h8;
    localparam logic [BEAT_W-1:0] BEATS_4 = 4'h4;

    // ==========================================================
    // timing: column delay in link clock cycles, clock periods in ns
    localparam int COLUMN_TO_COLUMN_DELAY = 4;
    localparam int SYS_CLK_NS = 8;
    localparam int LINK_CK_NS = 64;

    typedef enum logic [1:0] {
        DBRB_NOP = 2'h0,
        DBRB_ACT = 2'h1,
        DBRB_PRE = 2'h2,
        DBRB_RD = 2'h3
    } dbrb_cmd_t;

    // beats per burst for a mode and chop bit
    function automatic logic [BEAT_W-1:0] dbrb_beats(input logic [1:0] mode,
                                                     input logic chop_bit);
        if (mode == BL_FIXED4) begin
            return BEATS_4; // see R14
        end
        if (mode == BL_ON_THE_FLY && !chop_bit) begin
            return BEATS_4; // see R10
        end
        return BEATS_8; // see R13
    endfunction : dbrb_beats

    // read data: bank, row, column, beat
    function automatic logic [DQ_W-1:0] dbrb_data(input logic [BANK_W-1:0] ba,
                                                   input logic [ADDR_W-1:0] row,
                                                   input logic [COL_W-1:0] col,
                                                   input logic [2:0] beat);
        logic [2:0] idx;
        idx = beat ^ {col[COL_NIBBLE_BIT], 2'h0};
        return {ba, row[DATA_ROW_W-1:0],
                col[COL_NIBBLE_BIT+DATA_COL_W:COL_NIBBLE_BIT+1], idx};
    endfunction : dbrb_data

endpackage : dbrb_pkg

// ===== pkg/dbrb_link_if.sv
/*
 * The command/address/data link between controller and memory end.
 * Assumes the bench instantiates it once and hooks both ends to it.
 */
interface dbrb_link_if;
    logic ck;
    dbrb_pkg::dbrb_cmd_t cmd;
    logic [dbrb_pkg::BANK_W-1:0] ba;
    logic [dbrb_pkg::ADDR_W-1:0] addr;
    logic [dbrb_pkg::DQ_W-1:0] dq_o;
    logic dq_oe;
    logic dqs_o;
    logic dqs_oe;
    logic [dbrb_pkg::DQ_W-1:0] dq;
    logic dqs;

    // ==========================================================
    // an undriven bus is held low by termination
    assign dq = dq_oe ? dq_o : '0;
    assign dqs = dqs_oe ? dqs_o : 1'b0;

    modport ctrl (output ck, output cmd, output ba, output addr, input dq, input dqs);
    modport dram (input ck, input cmd, input ba, input addr,
                  output dq_o, output dq_oe, output dqs_o, output dqs_oe);
endinterface : dbrb_link_if

// ===== src/dbrb_fifo.sv
/*
 * Synchronous FIFO, valid/ready on both sides.
 * Assumes DEPTH is a power of two; both sides on the same clock.
 */
module dbrb_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input logic clk,
    input logic rst,
    input logic in_valid,
    output logic in_ready,
    input logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
    } dbrb_fifo_state_t;

    dbrb_fifo_state_t q;
    dbrb_fifo_state_t d;
    logic push;
    logic pop;

    assign in_ready = q.cnt != (AW+1)'(DEPTH);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rptr];
    assign count = q.cnt;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wptr] = in_data;
            d.wptr = q.wptr + 1'b1;
        end
        if (pop) begin
            d.rptr = q.rptr + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : dbrb_fifo

// ===== src/dbrb_ctrl_end.sv
/*
 * Controller end: divides down the link clock, issues activate,
 * precharge and read requests, buffers read beats in a FIFO.
 * Assumes requests are presented on SYS_CLK; MODE_BL matches the memory end.
 */
module dbrb_ctrl_end #(
    parameter int CK_HALF = dbrb_pkg::LINK_CK_NS / (2 * dbrb_pkg::SYS_CLK_NS),
    parameter int PRECHARGE_CK = 8,
    parameter int FIFO_DEPTH = 16
) (
    input logic SYS_CLK,
    input logic RST,
    dbrb_link_if.ctrl LINK,
    input logic [1:0] MODE_BL,
    input logic REQ_VALID,
    output logic REQ_READY,
    input dbrb_pkg::dbrb_cmd_t REQ_OP,
    input logic [dbrb_pkg::BANK_W-1:0] REQ_BANK,
    input logic [dbrb_pkg::ADDR_W-1:0] REQ_ADDR,
    output logic REQ_DROPPED,
    output logic RD_VALID,
    input logic RD_READY,
    output logic [dbrb_pkg::DQ_W-1:0] RD_DATA
);
    localparam int DIV_W = $clog2(CK_HALF + 1);
    localparam int PRE_W = $clog2(PRECHARGE_CK + 1);
    localparam int CCD_W = $clog2(dbrb_pkg::COLUMN_TO_COLUMN_DELAY + 1);
    localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;
    localparam int IF_W = CNT_W + 1;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic ck;
        dbrb_pkg::dbrb_cmd_t cmd;
        logic [dbrb_pkg::BANK_W-1:0] ba;
        logic [dbrb_pkg::ADDR_W-1:0] addr;
        logic pend;
        dbrb_pkg::dbrb_cmd_t op;
        logic [dbrb_pkg::BANK_W-1:0] op_ba;
        logic [dbrb_pkg::ADDR_W-1:0] op_addr;
        logic [dbrb_pkg::BANKS-1:0] open;
        logic [dbrb_pkg::BANKS-1:0][PRE_W-1:0] pre_cnt;
        logic [CCD_W-1:0] ccd;
        logic [IF_W-1:0] inflight;
        logic req_ready;
        logic dropped;
        logic dqs_meta;
        logic dqs_sync;
        logic dqs_prev;
        logic [dbrb_pkg::DQ_W-1:0] dq_meta;
        logic [dbrb_pkg::DQ_W-1:0] dq_sync;
    } dbrb_ctrl_state_t;

    dbrb_ctrl_state_t q;
    dbrb_ctrl_state_t d;
    logic ck_fall_now;
    logic beat_push;
    logic fifo_in_ready;
    logic [CNT_W-1:0] fifo_count;
    logic room;
    logic [dbrb_pkg::BEAT_W-1:0] rd_beats;

    // ==========================================================
    // each strobe edge carries one beat
    assign beat_push = q.dqs_sync != q.dqs_prev;
    assign ck_fall_now = (q.div == DIV_W'(CK_HALF - 1)) && q.ck;
    assign rd_beats = dbrb_pkg::dbrb_beats(MODE_BL, q.op_addr[dbrb_pkg::CHOP_BIT]);
    // a read is only sent when its whole burst is sure to fit
    assign room = fifo_in_ready && (int'(fifo_count) + int'(q.inflight)
                  + int'(dbrb_pkg::BEATS_8) <= FIFO_DEPTH);

    dbrb_fifo #(.WIDTH(dbrb_pkg::DQ_W), .DEPTH(FIFO_DEPTH)) i_dbrb_fifo (
        .clk(SYS_CLK),
        .rst(RST),
        .in_valid(beat_push),
        .in_ready(fifo_in_ready),
        .in_data(q.dq_sync),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA),
        .count(fifo_count)
    );

    always_comb begin
        d = q;
        d.dropped = 1'b0;
        d.dqs_meta = LINK.dqs;
        d.dqs_sync = q.dqs_meta;
        d.dqs_prev = q.dqs_sync;
        d.dq_meta = LINK.dq;
        d.dq_sync = q.dq_meta;
        if (beat_push && q.inflight != '0) begin
            d.inflight = q.inflight - 1'b1;
        end
        d.div = q.div + 1'b1;
        if (q.div == DIV_W'(CK_HALF - 1)) begin
            d.div = '0;
            d.ck = ~q.ck;
        end
        if (REQ_VALID && q.req_ready) begin
            d.pend = 1'b1;
            d.op = REQ_OP;
            d.op_ba = REQ_BANK;
            d.op_addr = REQ_ADDR;
        end
        // commands change at ck fall, stable at the rise
        if (ck_fall_now) begin
            d.cmd = dbrb_pkg::DBRB_NOP;
            for (int i = 0; i < dbrb_pkg::BANKS; i++) begin
                if (q.pre_cnt[i] != '0) begin
                    d.pre_cnt[i] = q.pre_cnt[i] - 1'b1;
                end
            end
            if (q.ccd != '0) begin
                d.ccd = q.ccd - 1'b1;
            end
            if (q.pend) begin
                d.ba = q.op_ba;
                d.addr = q.op_addr;
                unique case (q.op)
                    dbrb_pkg::DBRB_ACT: begin
                        if (q.open[q.op_ba]) begin
                            d.cmd = dbrb_pkg::DBRB_PRE; // see R3
                            d.addr = '0;
                            d.open[q.op_ba] = 1'b0;
                            d.pre_cnt[q.op_ba] = PRE_W'(PRECHARGE_CK - 1);
                        end else if (q.pre_cnt[q.op_ba] == '0) begin // see R5
                            d.cmd = dbrb_pkg::DBRB_ACT;
                            d.open[q.op_ba] = 1'b1;
                            d.pend = 1'b0;
                        end
                    end
                    dbrb_pkg::DBRB_PRE: begin
                        d.cmd = dbrb_pkg::DBRB_PRE;
                        d.pend = 1'b0;
                        for (int i = 0; i < dbrb_pkg::BANKS; i++) begin
                            if (q.op_addr[dbrb_pkg::AP_BIT] || q.op_ba == dbrb_pkg::BANK_W'(i)) begin
                                d.open[i] = 1'b0;
                                d.pre_cnt[i] = PRE_W'(PRECHARGE_CK - 1); // see R9
                            end
                        end
                    end
                    dbrb_pkg::DBRB_RD: begin
                        if (!q.open[q.op_ba]) begin
                            d.pend = 1'b0; // see R7
                            d.dropped = 1'b1;
                        end else if (q.ccd == '0 && room) begin // see R18
                            d.cmd = dbrb_pkg::DBRB_RD;
                            d.pend = 1'b0;
                            d.ccd = CCD_W'(dbrb_pkg::COLUMN_TO_COLUMN_DELAY - 1);
                            d.inflight = d.inflight + IF_W'(rd_beats);
                            if (q.op_addr[dbrb_pkg::AP_BIT]) begin // see R6
                                d.open[q.op_ba] = 1'b0;
                                d.pre_cnt[q.op_ba] = PRE_W'(PRECHARGE_CK - 1);
                            end
                        end
                    end
                    default: begin
                        d.pend = 1'b0;
                    end
                endcase
            end
        end
        d.req_ready = ~d.pend;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign LINK.ck = q.ck;
    assign LINK.cmd = q.cmd;
    assign LINK.ba = q.ba;
    assign LINK.addr = q.addr;
    assign REQ_READY = q.req_ready;
    assign REQ_DROPPED = q.dropped;
endmodule : dbrb_ctrl_end

// ===== src/dbrb_dram_end.sv
/*
 * Memory end: eight banks with open/idle state,
 * per-bank precharge timing and read bursts
 * with on-the-fly chop and an edge-aligned strobe.
 * Assumes link inputs come from another clock
 * domain, at least four SYS_CLK per link half
 * period, and are stable around the link rise.
 */

// Summary of operation
// R1 - activate opens addressed row in addressed bank
// R2 - row stays open until its bank precharges
// R3 - controller precharges before activating another row
// R4 - precharge closes one bank or all banks
// R5 - no activate before precharge period elapses
// R6 - other banks usable while one auto-precharges
// R7 - idle bank must be activated before reads
// R8 - precharge to idle bank is legal
// R9 - precharge period timed from latest precharge
// R10 - chop bit low four beats, high eight
// R11 - chop bit never part of column address
// R12 - auto-precharge independent of burst length choice
// R13 - mode 00 fixes eight, 01 selects on-the-fly
// R14 - mode 10 fixes four-beat chopped bursts
// R15 - first beat after additive plus column latency
// R16 - data launched on both strobe edges, aligned
// R17 - four or two data clocks, preamble, postamble
// R18 - reads four clocks apart stream seamlessly
module dbrb_dram_end #(
    parameter int ADDITIVE_LATENCY = 0,
    parameter int COLUMN_ACCESS_LATENCY = 6,
    parameter int PRECHARGE_CK = 8,
    parameter int RL_MAX = 16
) (
    input logic SYS_CLK,
    input logic RST,
    dbrb_link_if.dram LINK,
    input logic [1:0] MODE_BL,
    output logic [dbrb_pkg::BANKS-1:0] BANK_OPEN,
    output logic [dbrb_pkg::BANKS-1:0] BANK_PRECHARGING
);
    // ==========================================================
    // derived timing
    // read latency must lie in 2..RL_MAX link clocks
    localparam int READ_LATENCY = ADDITIVE_LATENCY + COLUMN_ACCESS_LATENCY; // see R15
    localparam int PRE_W = $clog2(PRECHARGE_CK + 1);

    typedef struct packed {
        logic vld;
        logic [dbrb_pkg::BEAT_W-1:0] len;
        logic [dbrb_pkg::BANK_W-1:0] ba;
        logic [dbrb_pkg::ADDR_W-1:0] row;
        logic [dbrb_pkg::COL_W-1:0] col;
    } dbrb_slot_t;

    typedef struct packed {
        logic ck_meta;
        logic ck_sync;
        logic ck_prev;
        dbrb_pkg::dbrb_cmd_t cmd_meta;
        dbrb_pkg::dbrb_cmd_t cmd_sync;
        logic [dbrb_pkg::BANK_W-1:0] ba_meta;
        logic [dbrb_pkg::BANK_W-1:0] ba_sync;
        logic [dbrb_pkg::ADDR_W-1:0] addr_meta;
        logic [dbrb_pkg::ADDR_W-1:0] addr_sync;
        logic [dbrb_pkg::BANKS-1:0] open;
        logic [dbrb_pkg::BANKS-1:0][dbrb_pkg::ADDR_W-1:0] row;
        logic [dbrb_pkg::BANKS-1:0][PRE_W-1:0] pre_cnt;
        dbrb_slot_t [RL_MAX-1:0] pipe;
        dbrb_slot_t cur;
        logic [dbrb_pkg::BEAT_W-1:0] beat;
        logic [dbrb_pkg::DQ_W-1:0] dq;
        logic dq_oe;
        logic dqs;
        logic dqs_oe;
        logic [dbrb_pkg::BANKS-1:0] open_out;
        logic [dbrb_pkg::BANKS-1:0] prech_out;
    } dbrb_dram_state_t;

    dbrb_dram_state_t q;
    dbrb_dram_state_t d;

    logic ck_rise;
    logic ck_fall;
    logic cmd_act;
    logic cmd_pre;
    logic cmd_rd;
    logic rd_ok;
    logic burst_busy;
    logic burst_start;
    logic preamble;
    logic send;
    dbrb_slot_t new_slot;
    dbrb_slot_t src;
    logic [dbrb_pkg::BEAT_W-1:0] src_beat;
    logic [dbrb_pkg::BANKS-1:0] act_hit;
    logic [dbrb_pkg::BANKS-1:0] pre_hit;

    // ==========================================================
    // link edges, from synchronised copies
    assign ck_rise = q.ck_sync & ~q.ck_prev;
    assign ck_fall = ~q.ck_sync & q.ck_prev;
    assign cmd_act = ck_rise && q.cmd_sync == dbrb_pkg::DBRB_ACT;
    assign cmd_pre = ck_rise && q.cmd_sync == dbrb_pkg::DBRB_PRE;
    assign cmd_rd = ck_rise && q.cmd_sync == dbrb_pkg::DBRB_RD;
    // a read to an idle bank is ignored
    assign rd_ok = cmd_rd && q.open[q.ba_sync]; // see R7

    // ==========================================================
    // read slot: column from low bits only
    always_comb begin
        new_slot.vld = rd_ok;
        new_slot.len = dbrb_pkg::dbrb_beats(MODE_BL, q.addr_sync[dbrb_pkg::CHOP_BIT]); // see R10
        new_slot.ba = q.ba_sync;
        new_slot.row = q.row[q.ba_sync];
        new_slot.col = q.addr_sync[dbrb_pkg::COL_W-1:0]; // see R11
    end

    // ==========================================================
    // per-bank command hits
    for (genvar b = 0; b < dbrb_pkg::BANKS; b++) begin : g_bank
        assign act_hit[b] = cmd_act && q.ba_sync == dbrb_pkg::BANK_W'(b);
        // auto-precharge is taken whatever the burst length, see R12
        assign pre_hit[b] = (cmd_pre && (q.addr_sync[dbrb_pkg::AP_BIT]
                            || q.ba_sync == dbrb_pkg::BANK_W'(b))) // see R4
                            || (rd_ok && q.addr_sync[dbrb_pkg::AP_BIT]
                            && q.ba_sync == dbrb_pkg::BANK_W'(b)); // see R6
    end

    // ==========================================================
    // burst engine selection
    assign burst_busy = q.beat != q.cur.len;
    assign burst_start = q.pipe[READ_LATENCY-1].vld;
    assign preamble = q.pipe[READ_LATENCY-2].vld;
    // a new burst starts on the rise the old one ends, see R18
    assign src = burst_busy ? q.cur : q.pipe[READ_LATENCY-1];
    assign src_beat = burst_busy ? q.beat : '0;
    assign send = (ck_rise && (burst_busy || burst_start)) || (ck_fall && burst_busy);

    always_comb begin
        d = q;
        d.ck_meta = LINK.ck;
        d.ck_sync = q.ck_meta;
        d.ck_prev = q.ck_sync;
        d.cmd_meta = LINK.cmd;
        d.cmd_sync = q.cmd_meta;
        d.ba_meta = LINK.ba;
        d.ba_sync = q.ba_meta;
        d.addr_meta = LINK.addr;
        d.addr_sync = q.addr_meta;

        for (int i = 0; i < dbrb_pkg::BANKS; i++) begin
            if (ck_rise && q.pre_cnt[i] != '0) begin
                d.pre_cnt[i] = q.pre_cnt[i] - 1'b1;
            end
            if (act_hit[i]) begin
                d.open[i] = 1'b1; // see R1
                d.row[i] = q.addr_sync; // see R1
            end
            // idle or already precharging banks accept it and restart the
            // period, see R8 and R9; the row otherwise stays put, see R2
            if (pre_hit[i]) begin
                d.open[i] = 1'b0;
                d.pre_cnt[i] = PRE_W'(PRECHARGE_CK);
            end
        end

        // one pipe slot per link clock
        if (ck_rise) begin
            d.pipe = {q.pipe[RL_MAX-2:0], new_slot}; // see R15
        end

        if (send) begin
            d.cur = src;
            d.beat = src_beat + 1'b1;
            d.dq = dbrb_pkg::dbrb_data(src.ba, src.row, src.col, src_beat[2:0]);
            d.dq_oe = 1'b1;
            d.dqs = ck_rise; // see R16
            d.dqs_oe = 1'b1;
        end else if (ck_rise) begin
            // strobe held low for one clock before data and released one half
            // clock after the last falling-edge beat, see R17
            d.dq_oe = 1'b0;
            d.dqs = 1'b0;
            d.dqs_oe = preamble;
        end

        d.open_out = d.open;
        for (int i = 0; i < dbrb_pkg::BANKS; i++) begin
            d.prech_out[i] = d.pre_cnt[i] != '0;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign LINK.dq_o = q.dq;
    assign LINK.dq_oe = q.dq_oe;
    assign LINK.dqs_o = q.dqs;
    assign LINK.dqs_oe = q.dqs_oe;
    assign BANK_OPEN = q.open_out;
    assign BANK_PRECHARGING = q.prech_out;
endmodule : dbrb_dram_end

// ===== dv/dbrb_link_monitor.sv
/*
 * Link checker: command framing and read frames.
 * Assumes both ends share SYS_CLK and RST.
 */
module dbrb_link_monitor (
    input logic SYS_CLK,
    input logic RST,
    input logic ck,
    input dbrb_pkg::dbrb_cmd_t cmd,
    input logic [dbrb_pkg::BANK_W-1:0] ba,
    input logic [dbrb_pkg::ADDR_W-1:0] addr,
    input logic dq_oe,
    input logic dqs_oe,
    input logic [dbrb_pkg::DQ_W-1:0] dq,
    input logic dqs
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking mon_cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // ==========================================================
    // helpers
    logic ck_q;
    logic dqs_q;
    logic [5:0] edges_q;
    logic rd_go;
    assign rd_go = ck_q && !ck && cmd == dbrb_pkg::DBRB_RD;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ck_q <= 1'b0;
            dqs_q <= 1'b0;
            edges_q <= 6'h00;
        end else begin
            ck_q <= ck;
            dqs_q <= dqs;
            edges_q <= dqs_oe ? edges_q + 6'(dqs != dqs_q) : 6'h00;
        end
    end
    // ==========================================================
    // assertions
    a_cmd_steady_high: assert property (ck && $past(ck) |-> $stable({cmd, ba, addr}))
        else $error("command moved in high ck");
    a_cmd_hold_period: assert property ($changed(cmd) && cmd != dbrb_pkg::DBRB_NOP |=> $stable(cmd)[*7])
        else $error("command held short");
    a_read_spacing: assert property (not (rd_go ##[1:31] rd_go))
        else $error("reads too close");
    a_preamble_shape: assert property ($rose(dqs_oe) |-> !dqs && !dq_oe)
        else $error("bad preamble");
    a_first_beat_time: assert property ($rose(dq_oe) |-> dqs && $past(dqs_oe, 8) && !$past(dqs_oe, 9))
        else $error("first beat late");
    a_strobe_aligned: assert property (dq_oe && $past(dq_oe) && $changed(dq) |-> $changed(dqs))
        else $error("data without strobe edge");
    a_postamble_end: assert property ($fell(dq_oe) |-> $fell(dqs_oe) && !$past(dqs))
        else $error("bad postamble");
    a_burst_beats: assert property ($fell(dqs_oe) |-> edges_q[1:0] == 2'h0 && edges_q != 6'h00)
        else $error("partial burst");
endmodule : dbrb_link_monitor

// ===== dv/dram_bank_row_read_burst_bench.sv
/*
 * Bench joining controller end and memory end over one link.
 * Assumes the precharge period is shortened to two link clocks.
 */
module dram_bank_row_read_burst_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PRE_CK = 2;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode_bl = 2'h1;
    logic req_valid = 1'b0;
    logic req_ready;
    dbrb_pkg::dbrb_cmd_t req_op = dbrb_pkg::DBRB_NOP;
    logic [2:0] req_bank = 3'h0;
    logic [12:0] req_addr = 13'h0000;
    logic req_dropped;
    logic rd_valid;
    logic rd_ready = 1'b1;
    logic [15:0] rd_data;
    logic [7:0] bank_open;
    logic [7:0] bank_pre;
    int fail_count = 0;
    int check_count = 0;
    always #(dbrb_pkg::SYS_CLK_NS / 2) sys_clk = ~sys_clk;
    dbrb_link_if i_dbrb_link_if ();
    dbrb_ctrl_end #(.PRECHARGE_CK(PRE_CK)) i_dbrb_ctrl_end (.SYS_CLK(sys_clk), .RST(rst),
        .LINK(i_dbrb_link_if), .MODE_BL(mode_bl), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ_OP(req_op), .REQ_BANK(req_bank), .REQ_ADDR(req_addr), .REQ_DROPPED(req_dropped),
        .RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data));
    dbrb_dram_end #(.PRECHARGE_CK(PRE_CK)) i_dbrb_dram_end (.SYS_CLK(sys_clk), .RST(rst),
        .LINK(i_dbrb_link_if), .MODE_BL(mode_bl), .BANK_OPEN(bank_open),
        .BANK_PRECHARGING(bank_pre));
    dbrb_link_monitor i_dbrb_link_monitor (.SYS_CLK(sys_clk), .RST(rst),
        .ck(i_dbrb_link_if.ck), .cmd(i_dbrb_link_if.cmd), .ba(i_dbrb_link_if.ba),
        .addr(i_dbrb_link_if.addr), .dq_oe(i_dbrb_link_if.dq_oe),
        .dqs_oe(i_dbrb_link_if.dqs_oe), .dq(i_dbrb_link_if.dq), .dqs(i_dbrb_link_if.dqs));
    // ==========================================================
    // shared tasks
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic send(input dbrb_pkg::dbrb_cmd_t op, input logic [2:0] b, input logic [12:0] a);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_bank <= b;
        req_addr <= a;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 2000);
        req_valid <= 1'b0;
        check_val("request taken", 16'h0001, 16'(n < 2000));
    endtask : send
    task automatic pop(input logic [2:0] b, input logic [12:0] row, input logic [12:0] col,
                       input int beats);
        int n;
        for (int i = 0; i < beats; i++) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (rd_valid !== 1'b1 && n < 500);
            check_val("beat valid", 16'h0001, {15'h0000, rd_valid});
            check_val("read beat", {b, row[5:0], col[6:3], 3'(i) ^ {col[2], 2'h0}}, rd_data);
        end
    endtask : pop
    task automatic tail();
        repeat (80) @(posedge sys_clk);
        check_val("no extra beat", 16'h0000, {15'h0000, rd_valid});
    endtask : tail
    task automatic wait_banks(input logic [7:0] exp);
        int n;
        n = 0;
        while (bank_open !== exp && n < 200) begin
            @(posedge sys_clk);
            n++;
        end
        check_val("open banks", {8'h00, exp}, {8'h00, bank_open});
    endtask : wait_banks
    // ==========================================================
    // scenarios
    task automatic s_stream();
        send(dbrb_pkg::DBRB_ACT, 3'h3, 13'h01A5);
        wait_banks(8'h08);
        send(dbrb_pkg::DBRB_RD, 3'h3, 13'h104C);
        send(dbrb_pkg::DBRB_RD, 3'h3, 13'h0010);
        pop(3'h3, 13'h01A5, 13'h104C, 8);
        pop(3'h3, 13'h01A5, 13'h0010, 4);
        tail();
    endtask : s_stream
    task automatic s_modes();
        logic [1:0] m;
        for (int k = 0; k < 4; k++) begin
            m = k[1] ? 2'h2 : 2'h0;
            mode_bl <= m;
            send(dbrb_pkg::DBRB_RD, 3'h3, {k[0], 12'h020});
            pop(3'h3, 13'h01A5, 13'h0020, (m == 2'h2) ? 4 : 8);
            tail();
        end
        mode_bl <= 2'h1;
    endtask : s_modes
    task automatic s_auto();
        int n;
        send(dbrb_pkg::DBRB_ACT, 3'h5, 13'h0777);
        send(dbrb_pkg::DBRB_RD, 3'h3, 13'h0408);
        send(dbrb_pkg::DBRB_RD, 3'h5, 13'h1030);
        wait_banks(8'h20);
        pop(3'h3, 13'h01A5, 13'h0408, 4);
        pop(3'h5, 13'h0777, 13'h1030, 8);
        send(dbrb_pkg::DBRB_RD, 3'h3, 13'h1000);
        n = 0;
        while (req_dropped !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        check_val("idle read dropped", 16'h0001, {15'h0000, req_dropped});
        tail();
    endtask : s_auto
    task automatic s_banks();
        int n;
        send(dbrb_pkg::DBRB_PRE, 3'h6, 13'h0000);
        n = 0;
        while (bank_pre[6] !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        n = 0;
        while (bank_pre[6] === 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check_val("precharge span", 16'(PRE_CK * 8), 16'(n));
        send(dbrb_pkg::DBRB_ACT, 3'h1, 13'h0011);
        send(dbrb_pkg::DBRB_ACT, 3'h2, 13'h0022);
        wait_banks(8'h26);
        send(dbrb_pkg::DBRB_PRE, 3'h2, 13'h0000);
        wait_banks(8'h22);
        send(dbrb_pkg::DBRB_PRE, 3'h0, 13'h0400);
        wait_banks(8'h00);
        send(dbrb_pkg::DBRB_ACT, 3'h1, 13'h0011);
        wait_banks(8'h02);
        check_val("bank 1 precharging", 16'h0000, {15'h0000, bank_pre[1]});
    endtask : s_banks
    task automatic s_stall();
        send(dbrb_pkg::DBRB_ACT, 3'h1, 13'h0033);
        rd_ready <= 1'b0;
        send(dbrb_pkg::DBRB_RD, 3'h1, 13'h1000);
        send(dbrb_pkg::DBRB_RD, 3'h1, 13'h1008);
        send(dbrb_pkg::DBRB_RD, 3'h1, 13'h1010);
        repeat (200) @(posedge sys_clk);
        check_val("request held", 16'h0000, {15'h0000, req_ready});
        rd_ready <= 1'b1;
        pop(3'h1, 13'h0033, 13'h1000, 8);
        pop(3'h1, 13'h0033, 13'h1008, 8);
        pop(3'h1, 13'h0033, 13'h1010, 8);
        tail();
    endtask : s_stall
    task automatic print_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        s_stream();
        s_modes();
        s_auto();
        s_banks();
        s_stall();
        print_verdict();
    end
    // run takes a few thousand cycles
    initial begin
        #200us;
        fail_count++;
        print_verdict();
    end
endmodule : dram_bank_row_read_burst_bench
